// ==== verilog/hrs_params.svh ====
// Constants of the host and RGB interface select block
`ifndef HRS_PARAMS_SVH
`define HRS_PARAMS_SVH

// Bus widths
`define HRS_DATA_W        18
`define HRS_CMD_W         16
`define HRS_SER_W         9

// Command word layout: address in the upper byte, data in the lower
`define HRS_CMD_ADDR_MSB  15
`define HRS_CMD_ADDR_LSB  8
`define HRS_CMD_DATA_MSB  7

// 16-to-18 bit expansion: RAM bit 12 copies word bit 15, RAM bit 0 copies bit 4
`define HRS_EXP_HI_SRC    15
`define HRS_EXP_LO_SRC    4

// RGB groups on shared data pins
`define HRS_RGB_G2_LSB    12
`define HRS_RGB_G1_LSB    6
`define HRS_RGB_GRP_W     6

// Serial frame lengths in bits per beat
`define HRS_SER_BITS_8    4'h8
`define HRS_SER_BITS_9    4'h9

// Synchroniser depth
`define HRS_SYNC_STAGES   2

// Reset values
`define HRS_RST_WORD      18'h00000
`define HRS_RST_BEAT      2'h0

`endif

// ==== verilog/hrs_pkg.sv ====
// Types shared by the host and RGB interface select block
package hrs_pkg;

  // System interface transfer modes
  typedef enum logic [3:0] {
    HRS_MODE_OFF = 4'h0,
    HRS_MODE_P18 = 4'h1,
    HRS_MODE_P16_9X2 = 4'h2,
    HRS_MODE_P16_16P2 = 4'h3,
    HRS_MODE_P16_16 = 4'h4,
    HRS_MODE_P8_6X3 = 4'h5,
    HRS_MODE_P8_8P8P2 = 4'h6,
    HRS_MODE_P8_8X2 = 4'h7,
    HRS_MODE_S9 = 4'h8,
    HRS_MODE_S8 = 4'h9
  } hrs_mode_e;

endpackage

// ==== verilog/hrs_serial_rx.sv ====
// Serial port shifter of the host interface, on the reference clock
`timescale 1ns/1ns
`default_nettype none
`include "hrs_params.svh"

module hrs_serial_rx (
  input  wire logic       i_ref_clk,
  input  wire logic       i_rst_b,
  input  wire logic       i_enable,
  input  wire logic       i_sclk_s,
  input  wire logic       i_si_s,
  input  wire logic       i_cs_b_s,
  input  wire logic       i_rw_s,
  input  wire logic [1:0] i_edge_sel,
  input  wire logic       i_nine_bit,
  input  wire logic [8:0] i_rd_word,
  output logic            o_beat,
  output logic [8:0]      o_word,
  output logic            o_rd_req,
  output logic            o_so,
  output logic            o_so_oe
);
  import hrs_pkg::*;

  logic       sclk_prev_reg;
  logic [3:0] bit_cnt_reg;
  logic [8:0] shin_reg;
  logic [8:0] shout_reg;
  logic       latch_rise;
  logic       latch_edge;
  logic       out_edge;
  logic       active;
  logic [3:0] beat_bits;

  assign latch_rise = ~(i_edge_sel[1] ^ i_edge_sel[0]);
  assign active     = i_enable & ~i_cs_b_s;
  assign latch_edge = active & (latch_rise ? (i_sclk_s & ~sclk_prev_reg)
                                           : (~i_sclk_s & sclk_prev_reg));
  assign out_edge   = active & (latch_rise ? (~i_sclk_s & sclk_prev_reg)
                                           : (i_sclk_s & ~sclk_prev_reg));
  assign beat_bits  = i_nine_bit ? `HRS_SER_BITS_9 : `HRS_SER_BITS_8;

  ////////////////////////////////////////////////////////////////////
  // Edge history of the synchronised serial clock
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sclk_prev_reg <= 1'b0;
    end else begin
      sclk_prev_reg <= i_sclk_s;
    end
  end

  // Bit counter; chip select high restarts the frame, the clock may stall
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      bit_cnt_reg <= 4'h0;
    end else if (!active) begin
      bit_cnt_reg <= 4'h0;
    end else if (latch_edge) begin
      bit_cnt_reg <= (bit_cnt_reg == beat_bits - 4'h1) ? 4'h0 : bit_cnt_reg + 4'h1;
    end
  end

  // Input shifter, first bit is the most significant
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      shin_reg <= 9'h000;
    end else if (latch_edge) begin
      shin_reg <= {shin_reg[7:0], i_si_s};
    end
  end

  // beat closes after eight or nine bits
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_beat <= 1'b0;
      o_word <= 9'h000;
    end else begin
      o_beat <= latch_edge & ~i_rw_s & (bit_cnt_reg == beat_bits - 4'h1);
      if (latch_edge && (bit_cnt_reg == beat_bits - 4'h1)) begin
        o_word <= i_nine_bit ? {shin_reg[7:0], i_si_s} : {1'b0, shin_reg[6:0], i_si_s};
      end
    end
  end

  // read direction shifts out on the output edge
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      shout_reg <= 9'h000;
      o_rd_req  <= 1'b0;
    end else begin
      o_rd_req <= active & i_rw_s & (bit_cnt_reg == 4'h0) & latch_edge;
      if (!active || (bit_cnt_reg == 4'h0 && !latch_edge && !out_edge)) begin
        shout_reg <= i_nine_bit ? i_rd_word : {i_rd_word[7:0], 1'b0};
      end else if (out_edge) begin
        shout_reg <= {shout_reg[7:0], 1'b0};
      end
    end
  end

  assign o_so    = shout_reg[8];
  assign o_so_oe = active & i_rw_s;

endmodule // hrs_serial_rx

`default_nettype wire

// ==== verilog/hrs_host_if.sv ====
// Host system interface and RGB input select of the source driver
`timescale 1ns/1ns
`default_nettype none
`include "hrs_params.svh"

module hrs_host_if (
  input  wire logic              i_ref_clk,
  input  wire logic              i_rst_b,
  // Mode straps
  input  wire logic              i_serial_parallel_select,
  input  wire logic              i_pin_sharing_select,
  input  wire logic              i_data_pin_owner_select,
  input  wire logic              i_bus_width_select_0,
  input  wire logic              i_bus_width_select_1,
  input  wire logic              i_rgb_width_select,
  input  wire logic              i_dot_format_select_2,
  input  wire logic              i_dot_format_select_1,
  input  wire logic              i_cpu_style_select,
  input  wire logic              i_serial_edge_select_1,
  input  wire logic              i_serial_edge_select_0,
  input  wire logic              i_msb_first_select,
  // Host bus pins
  input  wire logic              i_cs_b,
  input  wire logic              i_register_select,
  input  wire logic              i_rd_b,
  input  wire logic              i_wr_b,
  input  wire logic [17:0]       i_data,
  output logic      [17:0]       o_data,
  output logic                   o_data_oe,
  input  wire logic              i_sclk,
  input  wire logic              i_si,
  output logic                   o_so,
  output logic                   o_so_oe,
  // RGB pins
  input  wire logic              i_dotclk,
  input  wire logic [17:0]       i_rgb,
  // Core side, same clock
  input  wire logic [17:0]       i_rd_data,
  output hrs_pkg::hrs_mode_e     o_mode,
  output logic                   o_sys_enable,
  output logic                   o_rd_req,
  output logic                   o_rd_ram,
  output logic                   o_cmd_valid,
  output logic [7:0]             o_cmd_addr,
  output logic [7:0]             o_cmd_data,
  output logic                   o_pix_valid,
  output logic [17:0]            o_pix_data,
  output logic                   o_rgb_valid,
  output logic [17:0]            o_rgb_data
);
  import hrs_pkg::*;

  ////////////////////////////////////////////////////////////////////
  // Two-stage synchronisers for every pin
  localparam int SW = 13 + 18 + 18;

  logic [SW-1:0] sync1_reg;
  logic [SW-1:0] sync2_reg;
  logic [SW-1:0] pins_raw;

  assign pins_raw = {i_cs_b, i_register_select, i_rd_b, i_wr_b, i_sclk, i_si, i_dotclk,
                     i_serial_parallel_select, i_pin_sharing_select, i_data_pin_owner_select,
                     i_rgb_width_select, i_cpu_style_select, i_msb_first_select,
                     i_data, i_rgb};

  // First stage feeds only the second stage
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sync1_reg <= {{4{1'b1}}, {(SW-4){1'b0}}};
      sync2_reg <= {{4{1'b1}}, {(SW-4){1'b0}}};
    end else begin
      sync1_reg <= pins_raw;
      sync2_reg <= sync1_reg;
    end
  end

  logic        cs_b_s;
  logic        rs_s;
  logic        rd_b_s;
  logic        wr_b_s;
  logic        sclk_s;
  logic        si_s;
  logic        dotclk_s;
  logic        psx_s;
  logic        share_s;
  logic        owner_s;
  logic        rgbw_s;
  logic        c68_s;
  logic        msb_first_select_s;
  logic [17:0] data_s;
  logic [17:0] rgb_s;

  assign {cs_b_s, rs_s, rd_b_s, wr_b_s, sclk_s, si_s, dotclk_s, psx_s, share_s, owner_s,
          rgbw_s, c68_s, msb_first_select_s, data_s, rgb_s} = sync2_reg;

  // Width and dot format straps share one small synchroniser
  logic [3:0] bw1_reg;
  logic [3:0] bw2_reg;
  logic [1:0] edge1_reg;
  logic [1:0] edge2_reg;

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      bw1_reg   <= 4'h0;
      bw2_reg   <= 4'h0;
      edge1_reg <= 2'h0;
      edge2_reg <= 2'h0;
    end else begin
      bw1_reg   <= {i_bus_width_select_1, i_bus_width_select_0,
                    i_dot_format_select_2, i_dot_format_select_1};
      bw2_reg   <= bw1_reg;
      edge1_reg <= {i_serial_edge_select_1, i_serial_edge_select_0};
      edge2_reg <= edge1_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Mode decode
  hrs_mode_e mode;
  logic      par_en;
  logic      ser_en;

  always_comb begin
    mode = HRS_MODE_OFF;
    if (psx_s) begin
      if (bw2_reg[3:2] == 2'b01) mode = HRS_MODE_S9;
      if (bw2_reg[3:2] == 2'b11) mode = HRS_MODE_S8;
    end else begin
      unique case (bw2_reg)
        4'h0, 4'h1, 4'h2, 4'h3: mode = HRS_MODE_P18;
        4'h9: mode = HRS_MODE_P16_9X2;
        4'hB: mode = HRS_MODE_P16_16P2;
        4'h8: mode = HRS_MODE_P16_16;
        4'hD: mode = HRS_MODE_P8_6X3;
        4'hF: mode = HRS_MODE_P8_8P8P2;
        4'hE: mode = HRS_MODE_P8_8X2;
        default: mode = HRS_MODE_OFF;
      endcase
    end
  end

  // owner high under sharing locks out the system interface
  assign o_sys_enable = ~(share_s & owner_s);
  assign par_en = o_sys_enable & ~psx_s & (mode != HRS_MODE_OFF);
  assign ser_en = o_sys_enable & psx_s & (mode != HRS_MODE_OFF);
  assign o_mode = mode;

  ////////////////////////////////////////////////////////////////////
  // Parallel strobe decode
  logic rd_b_prev_reg;
  logic wr_b_prev_reg;
  logic par_wr;
  logic par_rd_start;
  logic par_rd_level;

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rd_b_prev_reg <= 1'b1;
      wr_b_prev_reg <= 1'b1;
    end else begin
      rd_b_prev_reg <= rd_b_s;
      wr_b_prev_reg <= wr_b_s;
    end
  end

  // i80: write on rising write strobe, read while read strobe low
  // M68: enable high, read/write picks direction, write on enable fall
  always_comb begin
    if (c68_s) begin
      par_wr       = ~rd_b_s & rd_b_prev_reg & ~wr_b_s;
      par_rd_start = rd_b_s & ~rd_b_prev_reg & wr_b_s;
      par_rd_level = rd_b_s & wr_b_s;
    end else begin
      par_wr       = wr_b_s & ~wr_b_prev_reg & rd_b_s;
      par_rd_start = ~rd_b_s & rd_b_prev_reg & wr_b_s;
      par_rd_level = ~rd_b_s & wr_b_s;
    end
    par_wr       = par_wr & ~cs_b_s & par_en;
    par_rd_start = par_rd_start & ~cs_b_s & par_en;
    par_rd_level = par_rd_level & ~cs_b_s & par_en;
  end

  ////////////////////////////////////////////////////////////////////
  // Serial port
  logic       ser_beat;
  logic [8:0] ser_word;
  logic       ser_rd_req;

  hrs_serial_rx u_serial (
    .i_ref_clk  (i_ref_clk),
    .i_rst_b    (i_rst_b),
    .i_enable   (ser_en),
    .i_sclk_s   (sclk_s),
    .i_si_s     (si_s),
    .i_cs_b_s   (cs_b_s),
    .i_rw_s     (wr_b_s),
    .i_edge_sel (edge2_reg),
    .i_nine_bit (mode == HRS_MODE_S9),
    .i_rd_word  (i_rd_data[8:0]),
    .o_beat     (ser_beat),
    .o_word     (ser_word),
    .o_rd_req   (ser_rd_req),
    .o_so       (o_so),
    .o_so_oe    (o_so_oe)
  );

  ////////////////////////////////////////////////////////////////////
  // Beat assembly into pixels and commands
  logic        beat;
  logic [17:0] beat_word;
  logic [1:0]  beat_idx_reg;
  logic        beat_rs_reg;
  logic [17:0] acc_reg;
  logic [4:0]  bw;
  logic [1:0]  last_idx;
  logic [17:0] acc_next;
  logic [17:0] mask;

  assign beat      = par_wr | ser_beat;
  assign beat_word = psx_s ? {9'h000, ser_word} : data_s;

  always_comb begin
    bw       = 5'd18;
    last_idx = 2'h0;
    if (!rs_s) begin
      unique case (mode)
        HRS_MODE_P8_6X3, HRS_MODE_P8_8P8P2, HRS_MODE_P8_8X2, HRS_MODE_S8: begin
          bw = 5'd8; last_idx = 2'h1;
        end
        HRS_MODE_S9: begin
          bw = 5'd9; last_idx = 2'h1;
        end
        default: bw = 5'd16;
      endcase
    end else begin
      unique case (mode)
        HRS_MODE_P16_9X2, HRS_MODE_S9: begin
          bw = 5'd9; last_idx = 2'h1;
        end
        HRS_MODE_P16_16P2: begin
          bw = (beat_idx_reg == 2'h0) ? 5'd16 : 5'd2; last_idx = 2'h1;
        end
        HRS_MODE_P16_16: bw = 5'd16;
        HRS_MODE_P8_6X3: begin
          bw = 5'd6; last_idx = 2'h2;
        end
        HRS_MODE_P8_8P8P2: begin
          bw = (beat_idx_reg == 2'h2) ? 5'd2 : 5'd8; last_idx = 2'h2;
        end
        HRS_MODE_P8_8X2, HRS_MODE_S8: begin
          bw = 5'd8; last_idx = 2'h1;
        end
        default: bw = 5'd18;
      endcase
    end
    mask     = ~(18'h3FFFF << bw);
    acc_next = (acc_reg << bw) | (beat_word & mask);
    // Six-bit beats may sit high in the byte
    if (rs_s && mode == HRS_MODE_P8_6X3 && msb_first_select_s) begin
      acc_next = (acc_reg << bw) | ((beat_word >> 2) & mask);
    end
  end

  function automatic logic [17:0] expand16(input logic [15:0] w);
    expand16 = {w[15:11], w[`HRS_EXP_HI_SRC], w[10:0], w[`HRS_EXP_LO_SRC]};
  endfunction

  // Beat counter restarts when the word type flips
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      beat_idx_reg <= `HRS_RST_BEAT;
      beat_rs_reg  <= 1'b0;
      acc_reg      <= `HRS_RST_WORD;
    end else if (beat) begin
      beat_rs_reg <= rs_s;
      if (beat_idx_reg >= last_idx || beat_rs_reg != rs_s) begin
        beat_idx_reg <= (last_idx == 2'h0 || beat_rs_reg == rs_s) ? 2'h0 : 2'h1;
        acc_reg      <= (beat_word & mask);
      end else begin
        beat_idx_reg <= beat_idx_reg + 2'h1;
        acc_reg      <= acc_next;
      end
    end
  end

  logic word_done;
  logic restart;

  assign restart   = beat_rs_reg != rs_s;
  assign word_done = beat & (restart ? (last_idx == 2'h0)
                                     : (beat_idx_reg == last_idx));

  // register select steers the finished word
  // low marks a command, high marks display data
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_cmd_valid <= 1'b0;
      o_pix_valid <= 1'b0;
      o_cmd_addr  <= 8'h00;
      o_cmd_data  <= 8'h00;
      o_pix_data  <= `HRS_RST_WORD;
    end else begin
      o_cmd_valid <= word_done & ~rs_s;
      o_pix_valid <= word_done & rs_s;
      if (word_done && !rs_s) begin
        if (mode == HRS_MODE_S9) begin
          o_cmd_addr <= acc_next[16:9];
          o_cmd_data <= acc_next[7:0];
        end else begin
          o_cmd_addr <= acc_next[`HRS_CMD_ADDR_MSB:`HRS_CMD_ADDR_LSB];
          o_cmd_data <= acc_next[`HRS_CMD_DATA_MSB:0];
        end
      end
      if (word_done && rs_s) begin
        unique case (mode)
          HRS_MODE_P16_16, HRS_MODE_P8_8X2, HRS_MODE_S8:
            o_pix_data <= expand16(acc_next[15:0]);
          HRS_MODE_P8_8P8P2:
            o_pix_data <= {acc_next[17:0]};
          default:
            o_pix_data <= acc_next;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Read path and data pin drive
  // read strobe drives the bus from the core word
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rd_req  <= 1'b0;
      o_rd_ram  <= 1'b0;
      o_data    <= `HRS_RST_WORD;
      o_data_oe <= 1'b0;
    end else begin
      o_rd_req  <= par_rd_start | ser_rd_req;
      if (par_rd_start || ser_rd_req) begin
        o_rd_ram <= rs_s;
      end
      o_data    <= i_rd_data;
      // Drive only while the strobe stays asserted, never under RGB ownership
      o_data_oe <= par_rd_level;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // RGB input path
  logic [17:0] rgb_src;
  logic        dot_prev_reg;

  // data pins may carry the video stream
  // sharing select picks the source pins
  // owner select steers shared data pins
  // owner low lets commands ride the strobes beside pixels
  // data pins map group by group
  // Select written inline: a function reading module state would not wake the assign
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_grp
      assign rgb_src[g*`HRS_RGB_GRP_W +: `HRS_RGB_GRP_W] =
        share_s ? data_s[g*`HRS_RGB_GRP_W +: `HRS_RGB_GRP_W]
                : rgb_s[g*`HRS_RGB_GRP_W +: `HRS_RGB_GRP_W];
    end
  endgenerate

  // Same group order on both sources, so the mapping is a straight copy

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      dot_prev_reg <= 1'b0;
    end else begin
      dot_prev_reg <= dotclk_s;
    end
  end

  // eighteen or sixteen bits per dot
  // sixteen-bit dots expand as the host words do
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rgb_valid <= 1'b0;
      o_rgb_data  <= `HRS_RST_WORD;
    end else begin
      o_rgb_valid <= dotclk_s & ~dot_prev_reg;
      if (dotclk_s && !dot_prev_reg) begin
        o_rgb_data <= rgbw_s ? expand16(rgb_src[15:0]) : rgb_src;
      end
    end
  end

endmodule // hrs_host_if

`default_nettype wire

// ==== dv/hrs_host_monitor.sv ====
// Port checker for the host and RGB interface select block
`timescale 1ns/1ns
`default_nettype none
module hrs_host_monitor
  import hrs_pkg::*;
(
  input wire logic        i_ref_clk,
  input wire logic        i_rst_b,
  input wire logic        i_pin_sharing_select,
  input wire logic        i_data_pin_owner_select,
  input wire logic        i_cpu_style_select,
  input wire logic        i_rgb_width_select,
  input wire logic        i_cs_b,
  input wire logic        i_register_select,
  input wire logic        i_wr_b,
  input wire logic        i_dotclk,
  input wire hrs_mode_e   o_mode,
  input wire logic        o_sys_enable,
  input wire logic        o_cmd_valid,
  input wire logic        o_pix_valid,
  input wire logic [17:0] o_pix_data,
  input wire logic        o_rgb_valid,
  input wire logic [17:0] o_rgb_data
);
  logic       both_hi;
  logic       wr_go;
  logic [3:0] idle_reg;
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);
  ////////////////////////////////////////////////////////////////////////////
  // Data pins claimed by the RGB side alone
  assign both_hi = i_pin_sharing_select & i_data_pin_owner_select;
  // Live i80 port in the single beat mode
  assign wr_go = !i_cs_b & !i_cpu_style_select & o_sys_enable & (o_mode == HRS_MODE_P18);
  // Idle chip select cycles, saturating so the count never wraps
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) idle_reg <= 4'h0;
    else if (!i_cs_b) idle_reg <= 4'h0;
    else if (idle_reg != 4'hF) idle_reg <= idle_reg + 4'h1;
  end
  ////////////////////////////////////////////////////////////////////////////
  no_sys_path_a: assert property (both_hi && $past(both_hi, 3) |-> !o_sys_enable)
    else $error("system port open while pins are RGB only");
  sys_path_on_a: assert property (!both_hi && !$past(both_hi, 3) |-> o_sys_enable)
    else $error("system port closed without cause");
  cs_quiet_a: assert property (idle_reg > 4'h7 |-> !o_cmd_valid && !o_pix_valid)
    else $error("transfer without chip select");
  cmd_latency_a: assert property ($rose(i_wr_b) && wr_go && !i_register_select |-> ##[3:5] o_cmd_valid)
    else $error("command write not delivered");
  pix_latency_a: assert property ($rose(i_wr_b) && wr_go && i_register_select |-> ##[3:5] o_pix_valid)
    else $error("pixel write not delivered");
  rgb_capture_a: assert property ($rose(i_dotclk) |-> ##[2:5] o_rgb_valid)
    else $error("dot clock edge not captured");
  rgb_pulse_a: assert property (o_rgb_valid |=> !o_rgb_valid)
    else $error("dot capture longer than one cycle");
  rgb_expand_a: assert property (o_rgb_valid && i_rgb_width_select |-> o_rgb_data[12] == o_rgb_data[17] && o_rgb_data[0] == o_rgb_data[5])
    else $error("16-bit dot expanded wrongly");
  pix_expand_a: assert property (o_pix_valid && o_mode == HRS_MODE_P16_16 |-> o_pix_data[12] == o_pix_data[17] && o_pix_data[0] == o_pix_data[5])
    else $error("16-bit word expanded wrongly");
endmodule // hrs_host_monitor
`default_nettype wire

// ==== dv/hrs_rgb_source.sv ====
// Video source model: dot clock bursts carrying one pixel word
`timescale 1ns/1ns
`default_nettype none
module hrs_rgb_source (
  input  wire logic        i_run,
  input  wire logic [17:0] i_val,
  output logic             o_dotclk,
  output logic [17:0]      o_pix
);
  // dot clock supplied only in bursts
  // Outside a burst the pins show the inverse, never a stale match
  initial begin
    o_dotclk = 1'b0;
    o_pix    = 18'h00000;
    forever begin
      if (i_run) begin
        o_pix = i_val;
        o_dotclk = 1'b1;
        #200;
        o_dotclk = 1'b0;
        #200;
      end else begin
        o_pix = ~i_val;
        @(i_run);
      end
    end
  end
endmodule // hrs_rgb_source
`default_nettype wire

// ==== dv/tb_top.sv ====
// Testbench of the host and RGB interface select block
`timescale 1ns/1ns
`default_nettype none
module tb_top
  import hrs_pkg::*;
;
  logic i_ref_clk, i_rst_b, i_serial_parallel_select, i_pin_sharing_select;
  logic i_data_pin_owner_select, i_bus_width_select_0, i_bus_width_select_1;
  logic i_rgb_width_select, i_dot_format_select_2, i_dot_format_select_1;
  logic i_cpu_style_select, i_serial_edge_select_1, i_serial_edge_select_0;
  logic i_msb_first_select, i_cs_b, i_register_select, i_rd_b, i_wr_b;
  logic i_sclk, i_si, run, o_sys_enable, o_cmd_valid, o_pix_valid, o_rgb_valid;
  logic [17:0] hd, val, i_rd_data, o_pix_data, o_rgb_data, lcmd, lpix, lrgb;
  logic [7:0]  o_cmd_addr, o_cmd_data;
  logic [17:0] rdq;
  logic        rdoe, rram;
  wire  [17:0] i_rgb, i_data;
  wire         i_dotclk;
  hrs_mode_e   o_mode;
  int          mismatches, checks, ncmd, npix, nrgb, ec, ep, er, tmo;
  logic [4:0]  cod [9] = '{5'h00, 5'h09, 5'h0B, 5'h08, 5'h0D, 5'h0F, 5'h0E, 5'h14, 5'h1C};
  ////////////////////////////////////////////////////////////////////////////
  hrs_host_if dut (
    .i_ref_clk, .i_rst_b, .i_serial_parallel_select, .i_pin_sharing_select,
    .i_data_pin_owner_select, .i_bus_width_select_0, .i_bus_width_select_1,
    .i_rgb_width_select, .i_dot_format_select_2, .i_dot_format_select_1,
    .i_cpu_style_select, .i_serial_edge_select_1, .i_serial_edge_select_0,
    .i_msb_first_select, .i_cs_b, .i_register_select, .i_rd_b, .i_wr_b, .i_data,
    .o_data(rdq), .o_data_oe(rdoe), .i_sclk, .i_si, .o_so(), .o_so_oe(), .i_dotclk, .i_rgb,
    .i_rd_data, .o_mode, .o_sys_enable, .o_rd_req(), .o_rd_ram(rram), .o_cmd_valid,
    .o_cmd_addr, .o_cmd_data, .o_pix_valid, .o_pix_data, .o_rgb_valid, .o_rgb_data);
  hrs_rgb_source u_src (.i_run(run), .i_val(val), .o_dotclk(i_dotclk), .o_pix(i_rgb));
  // Shared pins carry the video word only while a burst runs
  assign i_data = (run && i_pin_sharing_select) ? i_rgb : hd;
  // Reference clock, 50 ns period
  always #25 i_ref_clk = ~i_ref_clk;
  // Collect delivered words and cut a hung run short
  always @(posedge i_ref_clk) begin
    if (o_cmd_valid === 1'b1) begin
      ncmd++;
      lcmd = {2'h0, o_cmd_addr, o_cmd_data};
    end
    if (o_pix_valid === 1'b1) begin
      npix++;
      lpix = o_pix_data;
    end
    if (o_rgb_valid === 1'b1) begin
      nrgb++;
      lrgb = o_rgb_data;
    end
    tmo++;
    if (tmo == 5000) begin
      mismatches++;
      results();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask
  task automatic ck(input logic [17:0] g, input logic [17:0] e);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // Word counts against the expected tallies
  task automatic cn();
    ck(18'(ncmd), 18'(ec));
    ck(18'(npix), 18'(ep));
    ck(18'(nrgb), 18'(er));
  endtask
  function automatic logic [17:0] x16(input logic [15:0] w);
    return {w[15:11], w[15], w[10:0], w[4]};
  endfunction
  task automatic md(input logic [4:0] c);
    {i_serial_parallel_select, i_bus_width_select_1, i_bus_width_select_0} = c[4:2];
    {i_dot_format_select_2, i_dot_format_select_1} = c[1:0];
    cyc(3);
  endtask
  // One parallel beat; strobe phases of three clocks or more
  task automatic pw(input logic c, input logic r, input logic [17:0] d);
    i_cs_b = c;
    i_register_select = r;
    hd = d;
    if (i_cpu_style_select) i_rd_b = 1'b1;
    else i_wr_b = 1'b0;
    cyc(3);
    if (i_cpu_style_select) i_rd_b = 1'b0;
    else i_wr_b = 1'b1;
    cyc(4);
    i_cs_b = 1'b1;
    cyc(3);
  endtask
  // Serial write of sixteen clocks, 400 ns each, MSB first
  // whole sixteen-clock frame; data moves mid-way through the resting-level phase, away from both edges
  task automatic sw(input logic [15:0] w);
    i_cs_b = 1'b0;
    i_wr_b = 1'b0;
    i_register_select = 1'b0;
    cyc(1);
    for (int k = 15; k >= 0; k--) begin
      #100 i_si = w[k];
      #100 i_sclk = ~i_sclk;
      #200 i_sclk = ~i_sclk;
    end
    cyc(6);
    i_cs_b = 1'b1;
    i_wr_b = 1'b1;
    cyc(1);
  endtask
  // Four dot clock periods of one pixel word
  task automatic rgb(input logic [17:0] v);
    val = v;
    run = 1'b1;
    cyc(31);
    run = 1'b0;
    cyc(8);
  endtask
  task automatic results();
    if (mismatches == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {i_ref_clk, i_rst_b, i_pin_sharing_select, i_data_pin_owner_select} = 4'h0;
    {i_rgb_width_select, i_cpu_style_select, i_msb_first_select, run} = 4'h0;
    {i_serial_edge_select_1, i_serial_edge_select_0, i_register_select, i_si} = 4'h0;
    {i_cs_b, i_rd_b, i_wr_b, i_sclk} = 4'hF;
    {hd, val, i_rd_data} = {18'h00000, 18'h00000, 18'h00000};
    md(5'h00);
    cyc(1);
    i_rst_b = 1'b1;
    cyc(3);
    for (int m = 0; m < 9; m++) begin
      md(cod[m]);
      ck(18'(o_mode), 18'(m + 1));
    end
    md(5'h00);
    pw(1'b0, 1'b0, 18'h0A55A); ec++; cn(); ck(lcmd, 18'h0A55A);
    pw(1'b0, 1'b1, 18'h2ABCD); ep++; cn(); ck(lpix, 18'h2ABCD);
    pw(1'b1, 1'b0, 18'h01111); cn();
    {i_rd_data, i_register_select, i_cs_b, i_rd_b} = {18'h15A5A, 3'b100};
    cyc(5);
    ck(rdq, 18'h15A5A);
    ck({16'h0000, rdoe, rram}, 18'h00003);
    {i_cs_b, i_rd_b} = 2'b11;
    cyc(5);
    ck(18'(rdoe), 18'h00000);
    md(5'h08);
    pw(1'b0, 1'b1, 18'h0F00F); ep++; cn(); ck(lpix, x16(16'hF00F));
    md(5'h0E);
    pw(1'b0, 1'b0, 18'h0003C); pw(1'b0, 1'b0, 18'h000C3); ec++; cn(); ck(lcmd, 18'h03CC3);
    md(5'h00);
    i_wr_b = 1'b0;
    i_rd_b = 1'b0;
    i_cpu_style_select = 1'b1;
    cyc(3);
    pw(1'b0, 1'b0, 18'h01234); ec++; cn(); ck(lcmd, 18'h01234);
    i_cpu_style_select = 1'b0;
    i_rd_b = 1'b1;
    i_wr_b = 1'b1;
    md(5'h1C);
    for (int e = 0; e < 4; e++) begin
      {i_serial_edge_select_1, i_serial_edge_select_0} = 2'(e);
      i_sclk = ~i_serial_edge_select_1;
      cyc(3);
      sw(16'h5A00 + 16'(e)); ec++; cn(); ck(lcmd, 18'h05A00 + 18'(e));
    end
    md(5'h00);
    rgb(18'h2D3C5); er += 4; cn(); ck(lrgb, 18'h2D3C5);
    i_pin_sharing_select = 1'b1;
    i_data_pin_owner_select = 1'b1;
    cyc(3);
    pw(1'b0, 1'b0, 18'h00777); cn(); ck(18'(o_sys_enable), 18'h00000);
    rgb(18'h1B2A4); er += 4; cn(); ck(lrgb, 18'h1B2A4);
    i_data_pin_owner_select = 1'b0;
    i_rgb_width_select = 1'b1;
    cyc(3);
    rgb(18'h3F0F1); er += 4; cn(); ck(lrgb, x16(16'hF0F1));
    pw(1'b0, 1'b0, 18'h04321); ec++; cn(); ck(lcmd, 18'h04321);
    results();
  end
endmodule // tb_top
bind hrs_host_if hrs_host_monitor u_mon (.i_ref_clk, .i_rst_b, .i_pin_sharing_select,
  .i_data_pin_owner_select, .i_cpu_style_select, .i_rgb_width_select, .i_cs_b,
  .i_register_select, .i_wr_b, .i_dotclk, .o_mode, .o_sys_enable, .o_cmd_valid,
  .o_pix_valid, .o_pix_data, .o_rgb_valid, .o_rgb_data);
`default_nettype wire
